//--- hdl/cbs_bit_unit.sv
// Single-bit modify and test on an operand byte
`timescale 1ns/10ps
module cbs_bit_unit (
  input wire logic [7:0] operand,
  input wire logic [2:0] bit_sel,
  input wire logic clear,
  output logic [7:0] result,
  output logic bit_val
);

  // ----------------------------------------------------------------
  // Per-bit replace
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign result[i] = (bit_sel == 3'(i)) ? ~clear : operand[i];
  end

  assign bit_val = operand[bit_sel];

endmodule

//--- hdl/cbs_decode.sv
// Opcode classifier of the bus cycle sequencer
`timescale 1ns/10ps
module cbs_decode
  import cbs_pkg::*;
(
  input wire logic [7:0] opcode,
  output cbs_class_t cls,
  output logic [2:0] bit_sel,
  output logic bit_clr
);

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  always_comb begin
    bit_sel = opcode[3:1];
    bit_clr = opcode[0];
    // Opcodes of the memory modes are not sequenced here; they run
    // as two-cycle inherent so the core never hangs on them.
    cls = CLS_INH2;
    if (opcode[7:4] == OPH_BTB) begin
      cls = CLS_BTB;
    end else if (opcode[7:4] == OPH_BSC) begin
      cls = CLS_BSC;
    end else if (opcode[7:4] == OPH_REL) begin
      cls = CLS_REL;
    end else if (opcode[7:4] == OPH_INH_A || opcode[7:4] == OPH_INH_X) begin
      cls = CLS_INH3;
    end else if (opcode == OP_RTS) begin
      cls = CLS_RTS;
    end else if (opcode == OP_RTI) begin
      cls = CLS_RTI;
    end else if (opcode == OP_SWI) begin
      cls = CLS_SWI;
    end else if (opcode == OP_RSP) begin
      cls = CLS_RSP;
    end else if (opcode == OP_BSR) begin
      cls = CLS_BSR;
    end else if (opcode[7:4] == OPH_IMM) begin
      cls = CLS_IMM;
    end
  end

endmodule

//--- hdl/cbs_pkg.sv
// Shared constants and types of the bus cycle sequencer
package cbs_pkg;

  // ----------------------------------------------------------------
  // Address space
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int HI_W = ADDR_W - 8;
  localparam logic [ADDR_W-1:0] START_PC = 13'h0000;
  localparam logic [ADDR_W-1:0] SP_RESET = 13'h007F;
  localparam logic [ADDR_W-1:0] VEC_HI = 13'h1FFC;
  localparam logic [ADDR_W-1:0] VEC_LO = 13'h1FFD;
  localparam logic [ADDR_W-1:0] OFS1 = 13'h0001;
  localparam logic [ADDR_W-1:0] OFS2 = 13'h0002;
  localparam logic [ADDR_W-1:0] OFS3 = 13'h0003;
  localparam logic [HI_W-1:0] ZERO_HI = 5'h00;

  // ----------------------------------------------------------------
  // Cycle numbers within an instruction
  // ----------------------------------------------------------------
  localparam logic [3:0] CY1 = 4'h1;
  localparam logic [3:0] CY2 = 4'h2;
  localparam logic [3:0] CY3 = 4'h3;
  localparam logic [3:0] CY4 = 4'h4;
  localparam logic [3:0] CY5 = 4'h5;
  localparam logic [3:0] CY6 = 4'h6;
  localparam logic [3:0] CY7 = 4'h7;
  localparam logic [3:0] CY8 = 4'h8;
  localparam logic [3:0] CY9 = 4'h9;
  localparam logic [3:0] CY10 = 4'hA;

  // ----------------------------------------------------------------
  // Opcode map
  // ----------------------------------------------------------------
  localparam logic [3:0] OPH_BTB = 4'h0;
  localparam logic [3:0] OPH_BSC = 4'h1;
  localparam logic [3:0] OPH_REL = 4'h2;
  localparam logic [3:0] OPH_INH_A = 4'h4;
  localparam logic [3:0] OPH_INH_X = 4'h5;
  localparam logic [3:0] OPH_IMM = 4'hA;
  localparam logic [7:0] OP_RTI = 8'h80;
  localparam logic [7:0] OP_RTS = 8'h81;
  localparam logic [7:0] OP_SWI = 8'h83;
  localparam logic [7:0] OP_RSP = 8'h9C;
  localparam logic [7:0] OP_BSR = 8'hAD;

  typedef enum logic [3:0] {
    CLS_INH2, CLS_RSP, CLS_INH3, CLS_IMM, CLS_RTS, CLS_RTI,
    CLS_SWI, CLS_BSC, CLS_BTB, CLS_REL, CLS_BSR
  } cbs_class_t;

endpackage

//--- hdl/cbs_sequencer.sv
// Per-instruction bus cycle sequencer of the 8-bit core
`timescale 1ns/10ps
module cbs_sequencer
  import cbs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] ccr_in,
  input wire logic cond_true,
  output logic [ADDR_W-1:0] address,
  output logic rd_wr,
  output logic instruction_load_strobe,
  output logic [7:0] data_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] cyc_q, cyc_d;
  cbs_class_t cls_q, cls_d;
  logic [2:0] bsel_q, bsel_d;
  logic bit_clear_op_q, bit_clear_op_d;
  logic taken_q, taken_d;
  logic [ADDR_W-1:0] pc_q, pc_d;
  logic [ADDR_W-1:0] sp_q, sp_d;
  logic [ADDR_W-1:0] tgt_q, tgt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rw_q, rw_d;
  logic li_q, li_d;
  logic [7:0] dout_q, dout_d;

  cbs_class_t dec_cls;
  logic [2:0] dec_bit;
  logic dec_clr;
  logic [7:0] bit_result;
  logic bit_val;
  logic fetch;
  logic [ADDR_W-1:0] fetch_addr;
  logic [ADDR_W-1:0] rel_ofs;
  logic [ADDR_W-1:0] ret1;
  logic [ADDR_W-1:0] ret2;

  cbs_decode u_decode (
    .opcode(data_in),
    .cls(dec_cls),
    .bit_sel(dec_bit),
    .bit_clr(dec_clr)
  );

  cbs_bit_unit u_bit (
    .operand(data_in),
    .bit_sel(bsel_q),
    .clear(bit_clear_op_q),
    .result(bit_result),
    .bit_val(bit_val)
  );

  assign rel_ofs = {{HI_W{data_in[7]}}, data_in};
  assign ret1 = pc_q + OFS1;
  assign ret2 = pc_q + OFS2;

  // ----------------------------------------------------------------
  // Next bus cycle
  // ----------------------------------------------------------------
  // Read data of the current cycle is sampled at its closing edge,
  // so every branch below computes what the next cycle drives.
  always_comb begin
    cyc_d = cyc_q + 4'h1;
    cls_d = cls_q;
    bsel_d = bsel_q;
    bit_clear_op_d = bit_clear_op_q;
    taken_d = taken_q;
    pc_d = pc_q;
    sp_d = sp_q;
    tgt_d = tgt_q;
    addr_d = addr_q;
    rw_d = 1'b1;
    li_d = 1'b0;
    dout_d = dout_q;
    fetch = 1'b0;
    fetch_addr = ret1;
    if (cyc_q == CY1) begin
      cls_d = dec_cls;
      bsel_d = dec_bit;
      bit_clear_op_d = dec_clr;
      addr_d = ret1;
    end else begin
      unique case (cls_q)
        CLS_INH2: begin
          fetch = 1'b1;
        end
        CLS_RSP: begin
          sp_d = SP_RESET;
          fetch = 1'b1;
        end
        CLS_IMM: begin
          fetch = 1'b1;
          fetch_addr = ret2;
        end
        CLS_INH3: begin
          if (cyc_q == CY2) begin
            addr_d = ret1;
          end else begin
            fetch = 1'b1;
          end
        end
        CLS_RTS: begin
          if (cyc_q == CY2) begin
            addr_d = sp_q;
          end else if (cyc_q == CY5) begin
            tgt_d = {tgt_q[ADDR_W-1:8], data_in};
            addr_d = {tgt_q[ADDR_W-1:8], data_in};
            sp_d = addr_q;
          end else if (cyc_q == CY6) begin
            fetch = 1'b1;
            fetch_addr = tgt_q;
          end else begin
            addr_d = addr_q + OFS1;
            if (cyc_q == CY4) begin
              tgt_d[ADDR_W-1:8] = data_in[HI_W-1:0];
            end
          end
        end
        CLS_RTI: begin
          if (cyc_q == CY2) begin
            addr_d = sp_q;
          end else if (cyc_q == CY8) begin
            tgt_d = {tgt_q[ADDR_W-1:8], data_in};
            addr_d = {tgt_q[ADDR_W-1:8], data_in};
            sp_d = addr_q;
          end else if (cyc_q == CY9) begin
            fetch = 1'b1;
            fetch_addr = tgt_q;
          end else begin
            addr_d = addr_q + OFS1;
            if (cyc_q == CY7) begin
              tgt_d[ADDR_W-1:8] = data_in[HI_W-1:0];
            end
          end
        end
        CLS_SWI: begin
          if (cyc_q == CY2) begin
            addr_d = sp_q;
            rw_d = 1'b0;
            dout_d = ret1[7:0];
          end else if (cyc_q <= CY6) begin
            addr_d = addr_q - OFS1;
            rw_d = 1'b0;
            if (cyc_q == CY3) begin
              dout_d = 8'(ret1[ADDR_W-1:8]);
            end else if (cyc_q == CY4) begin
              dout_d = index_in;
            end else if (cyc_q == CY5) begin
              dout_d = acc_in;
            end else begin
              dout_d = ccr_in;
            end
          end else if (cyc_q == CY7) begin
            sp_d = addr_q - OFS1;
            addr_d = VEC_HI;
          end else if (cyc_q == CY8) begin
            tgt_d[ADDR_W-1:8] = data_in[HI_W-1:0];
            addr_d = VEC_LO;
          end else if (cyc_q == CY9) begin
            tgt_d = {tgt_q[ADDR_W-1:8], data_in};
            addr_d = {tgt_q[ADDR_W-1:8], data_in};
          end else begin
            fetch = 1'b1;
            fetch_addr = tgt_q;
          end
        end
        CLS_BSC: begin
          if (cyc_q == CY2) begin
            addr_d = {ZERO_HI, data_in};
          end else if (cyc_q == CY4) begin
            rw_d = 1'b0;
            dout_d = bit_result;
          end else if (cyc_q == CY5) begin
            fetch = 1'b1;
            fetch_addr = ret2;
          end
        end
        CLS_BTB: begin
          if (cyc_q == CY2) begin
            addr_d = {ZERO_HI, data_in};
          end else if (cyc_q == CY3) begin
            taken_d = bit_val ^ bit_clear_op_q;
            addr_d = ret2;
          end else if (cyc_q == CY5) begin
            fetch = 1'b1;
            fetch_addr = pc_q + OFS3;
            if (taken_q) begin
              fetch_addr = pc_q + OFS3 + rel_ofs;
            end
          end
        end
        CLS_REL: begin
          if (cyc_q == CY2) begin
            addr_d = ret1;
          end else begin
            fetch = 1'b1;
            fetch_addr = ret2;
            if (cond_true) begin
              fetch_addr = ret2 + rel_ofs;
            end
          end
        end
        CLS_BSR: begin
          if (cyc_q == CY2) begin
            addr_d = ret1;
          end else if (cyc_q == CY3) begin
            tgt_d = ret2 + rel_ofs;
            addr_d = ret2 + rel_ofs;
          end else if (cyc_q == CY4) begin
            addr_d = sp_q;
            rw_d = 1'b0;
            dout_d = ret2[7:0];
          end else if (cyc_q == CY5) begin
            addr_d = sp_q - OFS1;
            rw_d = 1'b0;
            dout_d = 8'(ret2[ADDR_W-1:8]);
          end else begin
            sp_d = sp_q - OFS2;
            fetch = 1'b1;
            fetch_addr = tgt_q;
          end
        end
      endcase
    end
    if (fetch) begin
      addr_d = fetch_addr;
      pc_d = fetch_addr;
      li_d = 1'b1;
      cyc_d = CY1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= CY1;
      cls_q <= CLS_INH2;
      bsel_q <= 3'h0;
      bit_clear_op_q <= 1'b0;
      taken_q <= 1'b0;
      pc_q <= START_PC;
      sp_q <= SP_RESET;
      tgt_q <= START_PC;
      addr_q <= START_PC;
      rw_q <= 1'b1;
      li_q <= 1'b1;
      dout_q <= 8'h00;
    end else begin
      cyc_q <= cyc_d;
      cls_q <= cls_d;
      bsel_q <= bsel_d;
      bit_clear_op_q <= bit_clear_op_d;
      taken_q <= taken_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      tgt_q <= tgt_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      li_q <= li_d;
      dout_q <= dout_d;
    end
  end

  assign address = addr_q;
  assign rd_wr = rw_q;
  assign instruction_load_strobe = li_q;
  assign data_out = dout_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic first_op;
  assign first_op = (cyc_q == CY1) && rst_n; // No attempt on the edge that releases reset

  li_first_a: assert property (li_q |-> rw_q && cyc_q == CY1 && addr_q == pc_q)
    else $error("strobe outside an opcode fetch");
  inh3_len_a: assert property (first_op && dec_cls == CLS_INH3 |->
    ##1 (!li_q && addr_q == pc_q + OFS1)[*2] ##1 li_q)
    else $error("inherent modify sequence wrong");
  inh2_len_a: assert property (first_op && dec_cls inside {CLS_INH2, CLS_IMM} |->
    ##1 (rw_q && addr_q == pc_q + OFS1) ##1 li_q)
    else $error("two-cycle instruction wrong");
  rts_seq_a: assert property (first_op && dec_cls == CLS_RTS |->
    ##2 (rw_q && addr_q == sp_q) ##1 (rw_q && addr_q == sp_q + OFS1)
    ##1 (rw_q && addr_q == sp_q + OFS2) ##2 li_q)
    else $error("subroutine return sequence wrong");
  swi_stack_a: assert property (first_op && dec_cls == CLS_SWI |->
    ##2 (!rw_q && addr_q == sp_q) ##1 (!rw_q && addr_q == sp_q - OFS1)
    ##1 (!rw_q)[*3] ##1 (rw_q && addr_q == VEC_HI) ##1 (rw_q && addr_q == VEC_LO)
    ##2 li_q)
    else $error("interrupt stacking sequence wrong");
  swi_vector_a: assert property (cyc_q == CY10 && cls_q == CLS_SWI |->
    rw_q && !li_q && addr_q == tgt_q ##1 li_q && addr_q == $past(tgt_q))
    else $error("handler fetch not at vector target");
  rti_seq_a: assert property (first_op && dec_cls == CLS_RTI |->
    ##2 (rw_q && addr_q == sp_q) ##1 rw_q[*5] ##1 (rw_q && !li_q) ##1 li_q)
    else $error("interrupt return sequence wrong");
  bsc_seq_a: assert property (first_op && dec_cls == CLS_BSC |->
    ##2 (rw_q && addr_q[ADDR_W-1:8] == ZERO_HI)[*2] ##1 !rw_q ##1 li_q)
    else $error("bit set or clear sequence wrong");
  btb_seq_a: assert property (first_op && dec_cls == CLS_BTB |->
    ##2 (addr_q[ADDR_W-1:8] == ZERO_HI) ##1 (addr_q == pc_q + OFS2)[*2] ##1 li_q)
    else $error("bit branch sequence wrong");
  btb_target_a: assert property (cyc_q == CY5 && cls_q == CLS_BTB |=>
    addr_q == $past(pc_q) + OFS3 + ($past(taken_q) ? $past(rel_ofs) : '0))
    else $error("bit branch target wrong");
  rel_target_a: assert property (cyc_q == CY3 && cls_q == CLS_REL |=>
    li_q && addr_q == $past(pc_q) + OFS2 + ($past(cond_true) ? $past(rel_ofs) : '0))
    else $error("relative branch target wrong");
  bsr_seq_a: assert property (first_op && dec_cls == CLS_BSR |->
    ##3 (rw_q && !li_q) ##1 (!rw_q && addr_q == sp_q)
    ##1 (!rw_q && addr_q == sp_q - OFS1) ##1 li_q)
    else $error("relative call sequence wrong");

  swi_seen_c: cover property (first_op && dec_cls == CLS_SWI ##10 li_q);
  rti_seen_c: cover property (first_op && dec_cls == CLS_RTI ##9 li_q);
  btb_taken_c: cover property (cyc_q == CY5 && cls_q == CLS_BTB && taken_q);

endmodule

//--- testbench/cbs_mem_model.sv
// Behavioural memory on the far side of the processor bus
`timescale 1ns/10ps
module cbs_mem_model
  import cbs_pkg::*;
(
  input wire logic clock,
  input wire logic [ADDR_W-1:0] address,
  input wire logic rd_wr,
  input wire logic [7:0] data_out,
  output logic [7:0] data_in
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] last_q = 8'h00;

  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = 8'h9D;
    end
  end

  // ----------------------------------------------------------------
  // Bus responder
  // ----------------------------------------------------------------
  // No wait states, so read data must follow the address in the same cycle.
  // On writes nobody drives the read path: show the inverse of the last byte
  // so a design that samples data_in there cannot pass by luck.
  assign data_in = rd_wr ? mem[address] : ~last_q;

  always @(posedge clock) begin
    if (rd_wr) begin
      last_q <= mem[address];
    end else begin
      mem[address] <= data_out;
    end
  end
endmodule

//--- testbench/cpu_bus_cycle_sequencer_bench.sv
// Self-checking bench tracing bus cycles of the sequencer against expected cycles
`timescale 1ns/10ps
module cpu_bus_cycle_sequencer_bench
  import cbs_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] data_in;
  logic [7:0] acc_in = 8'h00;
  logic [7:0] index_in = 8'h00;
  logic [7:0] ccr_in = 8'h00;
  logic cond_true = 1'b0;
  logic [ADDR_W-1:0] address;
  logic rd_wr;
  logic instruction_load_strobe;
  logic [7:0] data_out;
  int error_cnt = 0;
  int checks = 0;

  always #5 clock = ~clock;

  cbs_sequencer dut (
    .clock(clock),
    .rst_n(rst_n),
    .data_in(data_in),
    .acc_in(acc_in),
    .index_in(index_in),
    .ccr_in(ccr_in),
    .cond_true(cond_true),
    .address(address),
    .rd_wr(rd_wr),
    .instruction_load_strobe(instruction_load_strobe),
    .data_out(data_out)
  );

  cbs_mem_model far (
    .clock(clock),
    .address(address),
    .rd_wr(rd_wr),
    .data_out(data_out),
    .data_in(data_in)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One bus cycle, looked at mid-cycle once the launching edge has settled
  task automatic cyc(input logic [12:0] a, input logic rw, input logic li, input logic [7:0] d);
    @(negedge clock);
    check(16'(address), 16'(a), "address");
    check(16'(rd_wr), 16'(rw), "read/write level");
    check(16'(instruction_load_strobe), 16'(li), "load strobe");
    if (!rw) begin
      check(16'(data_out), 16'(d), "write data");
    end
  endtask

  task automatic op(input logic [12:0] a);
    cyc(a, 1'b1, 1'b1, 8'h00);
  endtask

  task automatic rd(input logic [12:0] a);
    cyc(a, 1'b1, 1'b0, 8'h00);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    cyc(a, 1'b0, 1'b0, d);
  endtask

  task automatic ld(input logic [12:0] a, input logic [7:0] b);
    far.mem[a] = b;
  endtask

  // Reset is asserted before memory is loaded so stray writes cannot spoil it
  task automatic halt;
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
  endtask

  task automatic go;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_short;
    halt();
    ld(13'h0000, 8'h48);
    ld(13'h0001, 8'hA6);
    ld(13'h0003, 8'h97);
    ld(13'h0004, 8'h9C);
    ld(13'h0005, 8'h5C);
    go();
    op(13'h0000);
    rd(13'h0001);
    rd(13'h0001);
    op(13'h0001);
    rd(13'h0002);
    op(13'h0003);
    rd(13'h0004);
    op(13'h0004);
    rd(13'h0005);
    op(13'h0005);
    rd(13'h0006);
    rd(13'h0006);
    op(13'h0006);
  endtask

  // A call moves the stack down; only a working stack reset puts the next push back at the top
  task automatic sc_rsp;
    halt();
    ld(13'h0000, 8'hAD);
    ld(13'h0001, 8'h00);
    ld(13'h0002, 8'h9C);
    ld(13'h0003, 8'hAD);
    ld(13'h0004, 8'h00);
    go();
    op(13'h0000);
    rd(13'h0001);
    rd(13'h0001);
    rd(13'h0002);
    wr(13'h007F, 8'h02);
    wr(13'h007E, 8'h00);
    op(13'h0002);
    rd(13'h0003);
    op(13'h0003);
    rd(13'h0004);
    rd(13'h0004);
    rd(13'h0005);
    wr(13'h007F, 8'h05);
    wr(13'h007E, 8'h00);
    op(13'h0005);
  endtask

  // Interrupt stacking, then a return that must pull back what was stacked
  task automatic sc_swi;
    halt();
    ld(13'h0000, 8'h83);
    ld(13'h1FFC, 8'h01);
    ld(13'h1FFD, 8'h23);
    ld(13'h0123, 8'h80);
    acc_in <= 8'h5A;
    index_in <= 8'hA5;
    ccr_in <= 8'hE3;
    go();
    op(13'h0000);
    rd(13'h0001);
    wr(13'h007F, 8'h01);
    wr(13'h007E, 8'h00);
    wr(13'h007D, 8'hA5);
    wr(13'h007C, 8'h5A);
    wr(13'h007B, 8'hE3);
    rd(13'h1FFC);
    rd(13'h1FFD);
    rd(13'h0123);
    op(13'h0123);
    rd(13'h0124);
    for (int i = 0; i < 6; i++) begin
      rd(13'h007A + 13'(i));
    end
    rd(13'h0001);
    op(13'h0001);
  endtask

  task automatic sc_call;
    halt();
    ld(13'h0000, 8'hAD);
    ld(13'h0001, 8'h10);
    ld(13'h0012, 8'h81);
    go();
    op(13'h0000);
    rd(13'h0001);
    rd(13'h0001);
    rd(13'h0012);
    wr(13'h007F, 8'h02);
    wr(13'h007E, 8'h00);
    op(13'h0012);
    rd(13'h0013);
    rd(13'h007D);
    rd(13'h007E);
    rd(13'h007F);
    rd(13'h0002);
    op(13'h0002);
  endtask

  task automatic sc_rel(input logic c, input logic [7:0] off, input logic [12:0] nxt);
    halt();
    ld(13'h0000, 8'h20);
    ld(13'h0001, off);
    cond_true <= c;
    go();
    op(13'h0000);
    rd(13'h0001);
    rd(13'h0001);
    op(nxt);
  endtask

  task automatic sc_bsc(input logic [7:0] opc, input logic [7:0] d, input logic [7:0] v,
                        input logic [7:0] res);
    halt();
    ld(13'h0000, opc);
    ld(13'h0001, d);
    ld(13'(d), v);
    go();
    op(13'h0000);
    rd(13'h0001);
    rd(13'(d));
    rd(13'(d));
    wr(13'(d), res);
    op(13'h0002);
  endtask

  task automatic sc_btb(input logic [7:0] opc, input logic [7:0] d, input logic [7:0] v,
                        input logic [7:0] off, input logic [12:0] nxt);
    halt();
    ld(13'h0000, opc);
    ld(13'h0001, d);
    ld(13'(d), v);
    ld(13'h0002, off);
    go();
    op(13'h0000);
    rd(13'h0001);
    rd(13'(d));
    rd(13'h0002);
    rd(13'h0002);
    op(nxt);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    sc_short();
    sc_swi();
    sc_call();
    sc_rsp();
    sc_rel(1'b1, 8'h80, 13'h1F82);
    sc_rel(1'b0, 8'h80, 13'h0002);
    sc_rel(1'b1, 8'h7F, 13'h0081);
    sc_bsc(8'h1B, 8'hFF, 8'hFF, 8'hDF);
    sc_bsc(8'h14, 8'h40, 8'h00, 8'h04);
    sc_btb(8'h0E, 8'h50, 8'h80, 8'h07, 13'h000A);
    sc_btb(8'h0F, 8'h50, 8'h80, 8'h07, 13'h0003);
    sc_btb(8'h01, 8'hFF, 8'hFE, 8'hF0, 13'h1FF3);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("mismatch at %0t: run did not finish in time", $time);
    print_verdict();
  end
endmodule
